// File: pkg/hsr_consts.svh
// Timing counts, ranges and scale factors of the handler result block
`ifndef HSR_CONSTS_SVH
`define HSR_CONSTS_SVH

`define HSR_CLK_NS       100
`define HSR_MS_NS        1000000
`define HSR_TICK_CYCLES  (`HSR_MS_NS / `HSR_CLK_NS)
`define HSR_CHAN_MIN     1
`define HSR_CHAN_MAX     100
`define HSR_DELAY_MIN_MS 400
`define HSR_DELAY_MAX_MS 30000
`define HSR_PCT_SCALE    10000
`define HSR_NUM_GRADES   8

`endif

// File: pkg/hsr_pkg.sv
// Types shared by the handler result block
package hsr_pkg;

    typedef enum logic [1:0] {
        HSR_MODE_CMP,
        HSR_MODE_BIN,
        HSR_MODE_SCAN
    } hsr_mode_t;

    typedef enum logic [1:0] {
        HSR_V_LOW,
        HSR_V_IN,
        HSR_V_HIGH
    } hsr_verdict_t;

    typedef enum logic [2:0] {
        HSR_IDLE,
        HSR_WAIT_CONV,
        HSR_WAIT_RES,
        HSR_FLUSH,
        HSR_DELAY,
        HSR_FINISH
    } hsr_state_t;

    // Custom output condition: mask over {pass, low, high, out}
    typedef struct packed {
        logic       invert;
        logic [3:0] mask;
    } hsr_cust_t;

    // Image of every result pin except the scan clock and strobe
    typedef struct packed {
        logic       pass;
        logic       fail;
        logic       high;
        logic       low;
        logic [7:0] grade;
        logic       grade_out;
        logic       cust_a;
        logic       cust_b;
        logic       conversion_done_flag;
        logic       ready;
        logic       relay;
        logic       s_pass;
        logic       s_low;
        logic       s_high;
    } hsr_pins_t;

    // Word handed across to the link domain
    typedef struct packed {
        hsr_pins_t pins;
        logic      clk_pulse;
        logic      scan_complete_strobe_pulse;
    } hsr_word_t;

endpackage

// File: rtl/hsr_judge.sv
// Absolute or percentage limit judgment of one resistance value
`timescale 1ns/1ns
`include "hsr_consts.svh"
module hsr_judge
    import hsr_pkg::*;
#(
    parameter int VAL_W = 24
) (
    // Value and limits
    input  wire logic               pct_mode,
    input  wire logic [VAL_W-1:0]   value,
    input  wire logic [VAL_W-1:0]   reference,
    input  wire logic [VAL_W-1:0]   upper,
    input  wire logic [VAL_W-1:0]   lower,
    // Verdict
    output hsr_verdict_t            verdict
);
    localparam int PW = 2 * VAL_W + 18;

    initial begin
        if (VAL_W < 8 || VAL_W > 32) begin
            $error("hsr_judge: VAL_W out of range");
        end
    end

    logic signed [PW-1:0] dev;
    logic signed [PW-1:0] hi_b;
    logic signed [PW-1:0] lo_b;

    // Cross-multiplied so no divider is needed; limits in 1/100 percent
    always_comb begin
        dev  = PW'(($signed({1'b0, value}) - $signed({1'b0, reference}))
               * $signed(18'(`HSR_PCT_SCALE)));
        hi_b = PW'($signed(upper) * $signed({1'b0, reference}));
        lo_b = PW'($signed(lower) * $signed({1'b0, reference}));
        if (pct_mode) begin
            if (dev > hi_b) begin
                verdict = HSR_V_HIGH;
            end else if (dev < lo_b) begin
                verdict = HSR_V_LOW;
            end else begin
                verdict = HSR_V_IN;
            end
        end else begin
            if (value > upper) begin
                verdict = HSR_V_HIGH;
            end else if (value < lower) begin
                verdict = HSR_V_LOW;
            end else begin
                verdict = HSR_V_IN;
            end
        end
    end
endmodule

// File: rtl/hsr_top.sv
// Handler and scan result outputs with trigger capture on the link clock
`timescale 1ns/1ns
`include "hsr_consts.svh"
module hsr_top
    import hsr_pkg::*;
#(
    parameter int VAL_W       = 24,
    parameter int TICK_CYCLES = `HSR_TICK_CYCLES
) (
    // Core clock and reset
    input  wire logic               CLK,
    input  wire logic               NRST,
    // Link clock
    input  wire logic               LINK_CLK,
    // Configuration
    input  hsr_mode_t               MODE,
    input  wire logic               EXT_TRIG_MODE,
    input  wire logic               TRIG_FALLING,
    input  wire logic               PCT_MODE,
    input  wire logic [VAL_W-1:0]   REFERENCE,
    input  wire logic [VAL_W-1:0]   UPPER_LIMIT,
    input  wire logic [VAL_W-1:0]   LOWER_LIMIT,
    input  wire logic [VAL_W-1:0]   GRADE_LO [`HSR_NUM_GRADES],
    input  wire logic [VAL_W-1:0]   GRADE_HI [`HSR_NUM_GRADES],
    input  hsr_cust_t               CUSTOM_A_COND,
    input  hsr_cust_t               CUSTOM_B_COND,
    input  wire logic [6:0]         CHANNEL_COUNT,
    input  wire logic [14:0]        SCAN_DELAY_MS,
    // Measurement core
    output logic                    MEAS_START,
    input  wire logic               CONV_DONE,
    input  wire logic               RESULT_VALID,
    input  wire logic [VAL_W-1:0]   RESULT_VALUE,
    // Status
    output logic                    PIN_MAP_SCAN,
    output logic [6:0]              SCAN_CHANNEL,
    // Handler pins
    input  wire logic               TRIGGER,
    output logic                    PASS,
    output logic                    FAIL,
    output logic                    HIGH,
    output logic                    LOW,
    output logic [7:0]              GRADE_SLOTS,
    output logic                    GRADE_OUT,
    output logic                    CUSTOM_LOGIC_OUT_A,
    output logic                    CUSTOM_LOGIC_OUT_B,
    output logic                    CONVERSION_DONE_FLAG,
    output logic                    READY,
    // Scan pins
    output logic                    SCAN_RELAY,
    output logic                    SCAN_PASS,
    output logic                    SCAN_LOW,
    output logic                    SCAN_HIGH,
    output logic                    SCAN_CLOCK,
    output logic                    SCAN_COMPLETE_STROBE
);

    initial begin
        if (VAL_W < 8 || VAL_W > 32 || TICK_CYCLES < 1 ||
            TICK_CYCLES > 16383) begin
            $error("hsr_top: parameter out of range");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [14:0] clamp15(input logic [14:0] v,
                                            input logic [14:0] lo,
                                            input logic [14:0] hi);
        logic [14:0] r;
        r = v;
        if (v < lo) begin
            r = lo;
        end else if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction

    function automatic logic custom_eval(input hsr_cust_t c,
                                         input logic [3:0] flags);
        return c.invert ^ (|(c.mask & flags));
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Core domain state

    typedef struct packed {
        hsr_state_t st;
        logic       tsync1;
        logic       tsync2;
        logic       tseen;
        logic       async1;
        logic       async2;
        logic       req;
        hsr_word_t  xfer;
        hsr_pins_t  img;
        logic       pend_clk;
        logic       pend_scan_complete_strobe;
        logic [6:0] chan;
        logic [6:0] nchan;
        logic [14:0] dly;
        logic [14:0] ms;
        logic [13:0] tick;
        logic       meas_start;
        logic       scan_map;
    } hsr_core_t;

    typedef struct packed {
        logic      rq1;
        logic      rq2;
        logic      ack;
        logic      t1;
        logic      t2;
        logic      t3;
        logic      e1;
        logic      e2;
        logic      trig_tgl;
        hsr_pins_t pins;
        logic      clk_due;
        logic      scan_complete_strobe_due;
        logic      sclk;
        logic      scan_complete_strobe;
    } hsr_link_t;

    hsr_core_t    s;
    hsr_core_t    next_s;
    hsr_link_t    l;
    hsr_link_t    next_l;
    logic [1:0]   link_rst;
    logic         link_nrst;
    hsr_verdict_t verdict;
    logic [7:0]   grade_hit;
    logic [7:0]   grade_one;
    logic         trig_evt;
    logic         link_idle;
    logic         fin_tick;

    hsr_judge #(
        .VAL_W     (VAL_W)
    ) u_judge (
        .pct_mode  (PCT_MODE),
        .value     (RESULT_VALUE),
        .reference (REFERENCE),
        .upper     (UPPER_LIMIT),
        .lower     (LOWER_LIMIT),
        .verdict   (verdict)
    );

    // Lowest matching grade wins so overlapping ranges still give one line
    always_comb begin
        grade_one = 8'h00;
        for (int i = 0; i < `HSR_NUM_GRADES; i++) begin
            grade_hit[i] = (RESULT_VALUE >= GRADE_LO[i]) &&
                           (RESULT_VALUE <= GRADE_HI[i]);
        end
        for (int i = `HSR_NUM_GRADES - 1; i >= 0; i--) begin
            if (grade_hit[i]) begin
                grade_one = 8'h01 << i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Core sequencer

    always_comb begin
        next_s = s;
        next_s.meas_start = 1'b0;
        // Link toggles enter stage one only; stage two alone reads it
        next_s.tsync1 = l.trig_tgl;
        next_s.async1 = l.ack;
        next_s.tsync2 = s.tsync1;
        next_s.async2 = s.async1;
        next_s.scan_map = (MODE == HSR_MODE_SCAN);
        trig_evt  = (s.tsync2 != s.tseen);
        link_idle = (s.async2 == s.req);
        fin_tick  = (s.tick == 14'(TICK_CYCLES - 1));
        next_s.tseen = s.tsync2;
        unique case (s.st)
            HSR_IDLE: begin
                // Triggers while busy are dropped: ready is low then
                if (trig_evt) begin
                    next_s.meas_start = 1'b1;
                    next_s.chan = 7'h01;
                    next_s.nchan = 7'(clamp15({8'h00, CHANNEL_COUNT},
                        15'(`HSR_CHAN_MIN), 15'(`HSR_CHAN_MAX)));
                    next_s.dly = clamp15(SCAN_DELAY_MS,
                        15'(`HSR_DELAY_MIN_MS),
                        15'(`HSR_DELAY_MAX_MS));
                    next_s.img.conversion_done_flag = 1'b0;
                    next_s.img.ready = 1'b0;
                    next_s.st = HSR_WAIT_CONV;
                end
            end
            HSR_WAIT_CONV: begin
                if (CONV_DONE) begin
                    next_s.img.conversion_done_flag = EXT_TRIG_MODE;
                    next_s.st = HSR_WAIT_RES;
                end
            end
            HSR_WAIT_RES: begin
                if (RESULT_VALID && MODE == HSR_MODE_SCAN) begin
                    next_s.img.relay  = 1'b1;
                    next_s.img.s_pass = (verdict == HSR_V_IN);
                    next_s.img.s_low  = (verdict == HSR_V_LOW);
                    next_s.img.s_high = (verdict == HSR_V_HIGH);
                    next_s.pend_clk = 1'b1;
                    next_s.st = HSR_FLUSH;
                end else if (RESULT_VALID) begin
                    // Held until the next result overwrites them
                    next_s.img.pass = (verdict == HSR_V_IN);
                    next_s.img.high = (verdict == HSR_V_HIGH);
                    next_s.img.low  = (verdict == HSR_V_LOW);
                    next_s.img.fail = (verdict != HSR_V_IN);
                    next_s.img.grade = grade_one;
                    next_s.img.grade_out = (grade_one == 8'h00);
                    if (MODE == HSR_MODE_CMP) begin
                        next_s.img.cust_a = custom_eval(CUSTOM_A_COND,
                            {verdict == HSR_V_IN, verdict == HSR_V_LOW,
                             verdict == HSR_V_HIGH, 1'b0});
                        next_s.img.cust_b = custom_eval(CUSTOM_B_COND,
                            {verdict == HSR_V_IN, verdict == HSR_V_LOW,
                             verdict == HSR_V_HIGH, 1'b0});
                    end else begin
                        next_s.img.cust_a = custom_eval(CUSTOM_A_COND,
                            {grade_one != 8'h00, 2'b00,
                             grade_one == 8'h00});
                        next_s.img.cust_b = custom_eval(CUSTOM_B_COND,
                            {grade_one != 8'h00, 2'b00,
                             grade_one == 8'h00});
                    end
                    next_s.img.ready = EXT_TRIG_MODE;
                    next_s.st = HSR_IDLE;
                end
            end
            HSR_FLUSH: begin
                // Wait until this group and its clock pulse left
                if (!s.pend_clk && link_idle) begin
                    if (s.chan >= s.nchan) begin
                        next_s.pend_scan_complete_strobe = 1'b1;
                        next_s.st = HSR_FINISH;
                    end else begin
                        next_s.ms = 15'h0000;
                        next_s.tick = 14'h0000;
                        next_s.st = HSR_DELAY;
                    end
                end
            end
            HSR_DELAY: begin
                next_s.tick = fin_tick ? 14'h0000 : s.tick + 14'h0001;
                if (fin_tick) begin
                    next_s.ms = s.ms + 15'h0001;
                end
                if (fin_tick && s.ms == s.dly - 15'h0001) begin
                    next_s.chan = s.chan + 7'h01;
                    next_s.img.relay = 1'b0;
                    next_s.meas_start = 1'b1;
                    next_s.st = HSR_WAIT_CONV;
                end
            end
            HSR_FINISH: begin
                if (!s.pend_scan_complete_strobe && link_idle) begin
                    next_s.st = HSR_IDLE;
                end
            end
        endcase

        // Outputs of the inactive mode stay low
        if (MODE != HSR_MODE_CMP) begin
            next_s.img.pass = 1'b0;
            next_s.img.fail = 1'b0;
            next_s.img.high = 1'b0;
            next_s.img.low  = 1'b0;
        end
        if (MODE != HSR_MODE_BIN) begin
            next_s.img.grade = 8'h00;
            next_s.img.grade_out = 1'b0;
        end
        if (MODE == HSR_MODE_SCAN) begin
            next_s.img.cust_a = 1'b0;
            next_s.img.cust_b = 1'b0;
        end else begin
            next_s.img.relay  = 1'b0;
            next_s.img.s_pass = 1'b0;
            next_s.img.s_low  = 1'b0;
            next_s.img.s_high = 1'b0;
        end
        if (!EXT_TRIG_MODE || MODE == HSR_MODE_SCAN) begin
            next_s.img.conversion_done_flag = 1'b0;
            next_s.img.ready = 1'b0;
        end

        // Word is only changed while the link has acknowledged the last
        if (link_idle && (s.pend_clk || s.pend_scan_complete_strobe ||
                          s.img != s.xfer.pins)) begin
            next_s.xfer.pins = s.img;
            next_s.xfer.clk_pulse = s.pend_clk;
            next_s.xfer.scan_complete_strobe_pulse = s.pend_scan_complete_strobe;
            if (s.pend_clk) begin
                next_s.pend_clk = 1'b0;
            end
            if (s.pend_scan_complete_strobe) begin
                next_s.pend_scan_complete_strobe = 1'b0;
            end
            next_s.req = ~s.req;
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link domain

    // Reset release aligned to the link clock
    always_ff @(posedge LINK_CLK or negedge NRST) begin
        if (!NRST) begin
            link_rst <= 2'b00;
        end else begin
            link_rst <= {link_rst[0], 1'b1};
        end
    end
    assign link_nrst = link_rst[1];

    always_comb begin
        next_l = l;
        next_l.rq1 = s.req;
        next_l.t1  = TRIGGER;
        next_l.e1  = TRIG_FALLING;
        next_l.rq2 = l.rq1;
        next_l.t2  = l.t1;
        next_l.t3  = l.t2;
        next_l.e2  = l.e1;
        next_l.sclk = l.clk_due;
        next_l.scan_complete_strobe = l.scan_complete_strobe_due;
        next_l.clk_due = 1'b0;
        next_l.scan_complete_strobe_due = 1'b0;
        // Edge chosen by configuration, seen on synchronised samples
        if (l.e2 ? (!l.t2 && l.t3) : (l.t2 && !l.t3)) begin
            next_l.trig_tgl = ~l.trig_tgl;
        end
        // Pins settle one link cycle before the clock or strobe pulse
        if (l.rq2 != l.ack) begin
            next_l.ack = l.rq2;
            next_l.pins = s.xfer.pins;
            next_l.clk_due = s.xfer.clk_pulse;
            next_l.scan_complete_strobe_due = s.xfer.scan_complete_strobe_pulse;
        end
    end

    always_ff @(posedge LINK_CLK or negedge link_nrst) begin
        if (!link_nrst) begin
            l <= '0;
        end else begin
            l <= next_l;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign MEAS_START           = s.meas_start;
    assign PIN_MAP_SCAN         = s.scan_map;
    assign SCAN_CHANNEL         = s.chan;
    assign PASS                 = l.pins.pass;
    assign FAIL                 = l.pins.fail;
    assign HIGH                 = l.pins.high;
    assign LOW                  = l.pins.low;
    assign GRADE_SLOTS          = l.pins.grade;
    assign GRADE_OUT            = l.pins.grade_out;
    assign CUSTOM_LOGIC_OUT_A   = l.pins.cust_a;
    assign CUSTOM_LOGIC_OUT_B   = l.pins.cust_b;
    assign CONVERSION_DONE_FLAG = l.pins.conversion_done_flag;
    assign READY                = l.pins.ready;
    assign SCAN_RELAY           = l.pins.relay;
    assign SCAN_PASS            = l.pins.s_pass;
    assign SCAN_LOW             = l.pins.s_low;
    assign SCAN_HIGH            = l.pins.s_high;
    assign SCAN_CLOCK           = l.sclk;
    assign SCAN_COMPLETE_STROBE = l.scan_complete_strobe;

endmodule

// File: testbench/hsr_properties.sv
// Concurrent checks on the ports of the handler result block
`timescale 1ns/1ns
module hsr_props
    import hsr_pkg::*;
(
    // Clocks and reset
    input wire logic       CLK,
    input wire logic       NRST,
    input wire logic       LINK_CLK,
    // Core side
    input hsr_mode_t       MODE,
    input wire logic       MEAS_START,
    input wire logic       PIN_MAP_SCAN,
    // Handler lines
    input wire logic       PASS,
    input wire logic       FAIL,
    input wire logic       HIGH,
    input wire logic       LOW,
    input wire logic [7:0] GRADE_SLOTS,
    input wire logic       GRADE_OUT,
    // Scan lines
    input wire logic       SCAN_RELAY,
    input wire logic       SCAN_PASS,
    input wire logic       SCAN_LOW,
    input wire logic       SCAN_HIGH,
    input wire logic       SCAN_CLOCK,
    input wire logic       SCAN_COMPLETE_STROBE
);
    // A line that is high for exactly one cycle
    sequence s_pulse(x);
        x ##1 !x;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    // Handler verdict lines
    a_fail_hilo: assert property (
        @(posedge LINK_CLK) disable iff (!NRST) FAIL == (HIGH || LOW))
        else $error("fail line wrong");
    a_verdict_single: assert property (
        @(posedge LINK_CLK) disable iff (!NRST) $onehot0({PASS, HIGH, LOW}))
        else $error("several verdict lines");
    a_grade_single: assert property (
        @(posedge LINK_CLK) disable iff (!NRST)
        $onehot0({GRADE_SLOTS, GRADE_OUT})) else $error("several grades");
    // Core side; the map lags the mode by one register
    a_start_single: assert property (
        @(posedge CLK) disable iff (!NRST) s_pulse(MEAS_START) or !MEAS_START)
        else $error("start pulse too long");
    a_map_follows: assert property (
        @(posedge CLK) disable iff (!NRST)
        PIN_MAP_SCAN == $past(MODE == HSR_MODE_SCAN)) else $error("pin map");
    // Scan group must be whole and settled while its clock is high
    a_clock_single: assert property (
        @(posedge LINK_CLK) disable iff (!NRST)
        $rose(SCAN_CLOCK) |-> s_pulse(SCAN_CLOCK)) else $error("scan clock");
    a_group_valid: assert property (
        @(posedge LINK_CLK) disable iff (!NRST) SCAN_CLOCK |-> SCAN_RELAY
        && $onehot({SCAN_PASS, SCAN_LOW, SCAN_HIGH})
        && $stable({SCAN_RELAY, SCAN_PASS, SCAN_LOW, SCAN_HIGH}))
        else $error("scan group not valid");
    a_strobe_single: assert property (
        @(posedge LINK_CLK) disable iff (!NRST) $rose(SCAN_COMPLETE_STROBE)
        |-> s_pulse(SCAN_COMPLETE_STROBE)) else $error("strobe too long");
endmodule

bind hsr_top hsr_props u_props (
    .CLK, .NRST, .LINK_CLK, .MODE, .MEAS_START, .PIN_MAP_SCAN, .PASS, .FAIL,
    .HIGH, .LOW, .GRADE_SLOTS, .GRADE_OUT, .SCAN_RELAY, .SCAN_PASS,
    .SCAN_LOW, .SCAN_HIGH, .SCAN_CLOCK, .SCAN_COMPLETE_STROBE
);

// File: testbench/hsr_fixture.sv
// Handler fixture model: trigger pulses and scan group capture
`timescale 1ns/1ns
module hsr_fixture (
    // Link clock, reset and bench requests
    input  wire logic       lclk,
    input  wire logic       nrst,
    input  wire logic       fire,
    input  wire logic       fall,
    // Pins of the block
    output logic            trig,
    input  wire logic [3:0] pins,
    input  wire logic       sck,
    input  wire logic       stb,
    // What was seen
    output logic [7:0]      clocks,
    output logic [7:0]      strobes,
    output logic [3:0]      group
);
    logic       fire_seen;
    logic [2:0] hold;
    ////////////////////////////////////////////////////////////////////////
    // One pulse per bench toggle, long enough for two sync flops
    always_ff @(posedge lclk or negedge nrst) begin
        if (!nrst) begin
            fire_seen <= 1'b0;
            hold      <= 3'h0;
        end else begin
            fire_seen <= fire;
            if (fire != fire_seen) begin
                hold <= 3'h6;
            end else if (hold != 3'h0) begin
                hold <= hold - 3'h1;
            end
        end
    end
    assign trig = fall ^ (hold != 3'h0);
    // Latch each group at its clock pulse, count the strobes
    always_ff @(posedge lclk or negedge nrst) begin
        if (!nrst) begin
            clocks  <= 8'h0;
            strobes <= 8'h0;
            group   <= 4'h0;
        end else begin
            if (sck) clocks <= clocks + 8'h1;
            if (sck) group <= pins;
            if (stb) strobes <= strobes + 8'h1;
        end
    end
endmodule

// File: testbench/tb.sv
// Self-checking bench for the handler result block
`timescale 1ns/1ns
module tb;
    import hsr_pkg::*;
    // Block inputs
    logic        clk = 1'b0;
    logic        lclk = 1'b0;
    logic        nrst = 1'b0;
    hsr_mode_t   mode = HSR_MODE_CMP;
    logic        ext = 1'b1;
    logic        fall = 1'b0;
    logic        pct = 1'b0;
    logic [23:0] hi = 24'hc8;
    logic [23:0] lo = 24'h64;
    logic [23:0] glo [8];
    logic [23:0] ghi [8];
    logic        conv = 1'b0;
    logic        rv = 1'b0;
    logic [23:0] val = 24'h0;
    logic        fire = 1'b0;
    // Block and fixture outputs
    logic        start, map, trig, pass, fail, high, low, gout, ca, cb;
    logic        conversion_done_flag, rdy, rel, sp, sl, sh, sck, stb;
    logic [7:0]  slots, clocks, strobes;
    logic [6:0]  chan;
    logic [3:0]  group;
    logic [23:0] starts = 24'h0;
    int          miscompares = 0;
    int          checks_done = 0;
    ////////////////////////////////////////////////////////////////////////
    // Core clock 100 ns; link clock 15 ns on its own phase
    always #50 clk = ~clk;
    always begin
        #7 lclk = ~lclk;
        #8 lclk = ~lclk;
    end
    // Every launched measurement is counted
    always @(posedge clk) if (start === 1'b1) starts <= starts + 24'h1;
    hsr_top #(.TICK_CYCLES(2)) dut (
        .CLK(clk), .NRST(nrst), .LINK_CLK(lclk), .MODE(mode),
        .EXT_TRIG_MODE(ext), .TRIG_FALLING(fall), .PCT_MODE(pct),
        .REFERENCE(24'h3e8), .UPPER_LIMIT(hi), .LOWER_LIMIT(lo),
        .GRADE_LO(glo), .GRADE_HI(ghi),
        .CUSTOM_A_COND(hsr_cust_t'(5'h06)),
        .CUSTOM_B_COND(hsr_cust_t'(5'h16)), .CHANNEL_COUNT(7'h03),
        .SCAN_DELAY_MS(15'h190), .MEAS_START(start), .CONV_DONE(conv),
        .RESULT_VALID(rv), .RESULT_VALUE(val), .PIN_MAP_SCAN(map),
        .SCAN_CHANNEL(chan), .TRIGGER(trig), .PASS(pass), .FAIL(fail),
        .HIGH(high), .LOW(low), .GRADE_SLOTS(slots), .GRADE_OUT(gout),
        .CUSTOM_LOGIC_OUT_A(ca), .CUSTOM_LOGIC_OUT_B(cb),
        .CONVERSION_DONE_FLAG(conversion_done_flag), .READY(rdy), .SCAN_RELAY(rel),
        .SCAN_PASS(sp), .SCAN_LOW(sl), .SCAN_HIGH(sh), .SCAN_CLOCK(sck),
        .SCAN_COMPLETE_STROBE(stb));
    hsr_fixture fx (
        .lclk(lclk), .nrst(nrst), .fire(fire), .fall(fall), .trig(trig),
        .pins({rel, sp, sl, sh}), .sck(sck), .stb(stb), .clocks(clocks),
        .strobes(strobes), .group(group));
    ////////////////////////////////////////////////////////////////////////
    // Compare one value
    task automatic chk(input string n, input logic [23:0] s, e);
        checks_done++;
        if (s !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    // A used-up wait ends the run
    task automatic timeout(input logic ok);
        if (ok !== 1'b1) begin
            miscompares++;
            tally_and_finish();
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Optional trigger, then answer as the core; dbl retriggers while busy
    task automatic measure(input logic [23:0] v, input logic trg, dbl);
        int i;
        if (trg) @(posedge clk) fire <= ~fire;
        for (i = 0; i < 2000 && start !== 1'b1; i++) @(negedge clk);
        timeout(start === 1'b1);
        if (dbl) @(posedge clk) fire <= ~fire;
        repeat (8) @(posedge clk);
        conv <= 1'b1;
        @(posedge clk) conv <= 1'b0;
        rv <= 1'b1;
        val <= v;
        @(posedge clk) rv <= 1'b0;
        for (i = 0; i < 100 && ext && rdy !== 1'b1; i++) @(negedge clk);
        timeout(!ext || rdy === 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        int i;
        int j;
        logic [23:0] v [8];
        logic [3:0]  e [8];
        v = '{24'h63, 24'h64, 24'hc8, 24'hc9,
              24'h41a, 24'h41b, 24'h3b6, 24'h3b5};
        e = '{4'h5, 4'h8, 4'h8, 4'h6, 4'h8, 4'h6, 4'h8, 4'h5};
        for (i = 0; i < 8; i++) begin
            glo[i] = 24'(i * 256);
            ghi[i] = 24'(i * 256 + 255);
        end
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        // Compare: limit edges absolute, then percent on a falling edge
        for (i = 0; i < 8; i++) begin
            if (i == 4) begin
                pct <= 1'b1;
                fall <= 1'b1;
                hi <= 24'h1f4;
                lo <= 24'hfffe0c;
                repeat (10) @(posedge clk);
            end
            measure(v[i], 1'b1, i == 0);
            chk("verdict", {pass, fail, high, low}, e[i]);
            chk("custom", {ca, cb}, {e[i][2], ~e[i][2]});
            chk("eot ready", {conversion_done_flag, rdy}, 2'h3);
            chk("grades", {slots, gout}, 9'h0);
        end
        chk("starts", starts, 24'h8);
        $display("test compare done");
        // Binning: each grade in turn, then a value outside them all
        mode <= HSR_MODE_BIN;
        pct <= 1'b0;
        for (i = 0; i < 9; i++) begin
            measure(24'(i * 256 + 128), 1'b1, 1'b0);
            chk("slots", {slots, gout}, i < 8 ? {8'(1 << i), 1'b0} : 9'h1);
            chk("compare", {pass, fail, high, low}, 4'h0);
        end
        $display("test binning done");
        // Scan of three channels graded low, in, high, then the strobe
        mode <= HSR_MODE_SCAN;
        ext <= 1'b0;
        hi <= 24'hc8;
        lo <= 24'h64;
        repeat (10) @(posedge clk);
        chk("pin map", map, 1'b1);
        for (i = 1; i < 4; i++) begin
            measure(24'(i * 80), i == 1, 1'b0);
            for (j = 0; j < 200 && clocks != 8'(i); j++) @(negedge clk);
            timeout(clocks == 8'(i));
            chk("group", group, i == 1 ? 4'ha : i == 2 ? 4'hc : 4'h9);
            chk("channel", chan, 7'(i));
            // Next start no sooner than 400 ms of two-cycle ticks
            for (j = 0; i < 3 && j < 900 && start !== 1'b1; j++)
                @(negedge clk);
            if (i < 3) chk("pause", j >= 800 && j < 820, 1'b1);
        end
        for (j = 0; j < 2000 && strobes == 8'h0; j++) @(negedge clk);
        timeout(strobes != 8'h0);
        repeat (20) @(negedge clk);
        chk("strobes", strobes, 8'h1);
        chk("clocks", clocks, 8'h3);
        chk("idle", {pass, conversion_done_flag, rdy, ca, cb}, 5'h0);
        chk("starts", starts, 24'h14);
        $display("test scan done");
        tally_and_finish();
    end
endmodule
